// ### rtl/see_master.sv
/*
  Bus master end: runs current reads, random reads and byte writes on the link.
  Assumes the user holds a command stable while cmd_valid is high and cmd_ready low.
*/
module see_master
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire see_pkg::see_cmd_t cmd_kind,
  input wire logic [2:0] cmd_sel,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_len,
  // Read data stream
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  // Completion
  output logic done,
  output logic nack,
  // Link
  see_if.master link
);
  see_pkg::see_mst_state_t state_reg;
  see_pkg::see_stage_t stage_reg;
  see_pkg::see_cmd_t kind_reg;
  logic [7:0] div_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [7:0] remain_reg;
  logic [2:0] sel_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic ack_reg;
  logic scl_reg;
  logic oe_reg;
  logic sda_s1;
  logic sda_s2;
  logic head_v, tail_v;
  logic [7:0] head_d, tail_d;
  logic tick, push, in_ready, hold, pop;

  assign link.scl = scl_reg;
  assign link.m_sda_o = 1'b0;
  assign link.m_sda_oe = oe_reg;
  assign rd_valid = head_v;
  assign rd_data = head_d;
  assign tick = (div_reg == see_pkg::QUARTER_LAST);
  assign in_ready = ~tail_v;
  assign pop = head_v & rd_ready;
  // The ack slot is held with SCL low until the buffer has room.
  assign hold = (state_reg == see_pkg::MS_RX) && (bit_reg == see_pkg::BYTE_BITS)
    && (q_reg == see_pkg::Q_DRIVE) && !in_ready;
  assign push = tick && !hold && (state_reg == see_pkg::MS_RX)
    && (bit_reg == see_pkg::BYTE_BITS) && (q_reg == see_pkg::Q_DRIVE);

  // ------------------------------------------------------------
  // SCL divider and SDA synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      div_reg <= 8'h00;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end
    else
    begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      div_reg <= (state_reg == see_pkg::MS_IDLE || tick) ? 8'h00 : div_reg + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Two-entry read buffer
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      head_v <= 1'b0;
      tail_v <= 1'b0;
      head_d <= 8'h00;
      tail_d <= 8'h00;
    end
    else if (pop)
    begin
      if (tail_v)
      begin
        head_d <= tail_d;
        tail_v <= 1'b0;
      end
      else
      begin
        head_v <= push;
        head_d <= sh_reg;
      end
    end
    else if (push)
    begin
      if (head_v)
      begin
        tail_v <= 1'b1;
        tail_d <= sh_reg;
      end
      else
      begin
        head_v <= 1'b1;
        head_d <= sh_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= see_pkg::MS_IDLE;
      stage_reg <= see_pkg::SG_DEVW;
      kind_reg <= see_pkg::CMD_CUR_READ;
      q_reg <= see_pkg::Q_DRIVE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      remain_reg <= 8'h00;
      sel_reg <= 3'h0;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      ack_reg <= 1'b0;
      scl_reg <= 1'b1;
      oe_reg <= 1'b0;
      cmd_ready <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (state_reg == see_pkg::MS_IDLE)
      begin
        scl_reg <= 1'b1;
        oe_reg <= 1'b0;
        cmd_ready <= 1'b1;
        if (cmd_valid && cmd_ready)
        begin
          cmd_ready <= 1'b0;
          nack <= 1'b0;
          kind_reg <= cmd_kind;
          sel_reg <= cmd_sel;
          addr_reg <= cmd_addr;
          wdata_reg <= cmd_wdata;
          remain_reg <= cmd_len;
          q_reg <= see_pkg::Q_DRIVE;
          state_reg <= see_pkg::MS_START;
          stage_reg <= (cmd_kind == see_pkg::CMD_CUR_READ) ? see_pkg::SG_DEVR
            : see_pkg::SG_DEVW;
        end
      end
      else if (tick && !hold)
      begin
        q_reg <= q_reg + 2'h1;
        unique case (state_reg)
          see_pkg::MS_START:
          begin
            unique case (q_reg)
              see_pkg::Q_DRIVE:
              begin
                scl_reg <= 1'b0;
                oe_reg <= 1'b0;
              end
              see_pkg::Q_RISE: scl_reg <= 1'b1;
              see_pkg::Q_SAMPLE: oe_reg <= 1'b1;
              see_pkg::Q_FALL:
              begin
                scl_reg <= 1'b0;
                bit_reg <= 4'h0;
                sh_reg <= {see_pkg::DEV_TYPE, sel_reg, stage_reg == see_pkg::SG_DEVR};
                state_reg <= see_pkg::MS_TX;
              end
            endcase
          end
          see_pkg::MS_TX:
          begin
            unique case (q_reg)
              see_pkg::Q_DRIVE: oe_reg <= (bit_reg != see_pkg::BYTE_BITS) & ~sh_reg[7];
              see_pkg::Q_RISE: scl_reg <= 1'b1;
              see_pkg::Q_SAMPLE: ack_reg <= ~sda_s2;
              see_pkg::Q_FALL:
              begin
                scl_reg <= 1'b0;
                if (bit_reg != see_pkg::BYTE_BITS)
                begin
                  bit_reg <= bit_reg + 4'h1;
                  if (bit_reg != see_pkg::LAST_BIT)
                    sh_reg <= {sh_reg[6:0], 1'b0};
                end
                else if (!ack_reg)
                begin
                  nack <= 1'b1;
                  state_reg <= see_pkg::MS_STOP;
                end
                else
                begin
                  bit_reg <= 4'h0;
                  unique case (stage_reg)
                    see_pkg::SG_DEVW:
                    begin
                      sh_reg <= addr_reg;
                      stage_reg <= see_pkg::SG_ADDR;
                    end
                    see_pkg::SG_ADDR:
                    begin
                      sh_reg <= wdata_reg;
                      stage_reg <= (kind_reg == see_pkg::CMD_WRITE) ? see_pkg::SG_DATA
                        : see_pkg::SG_DEVR;
                      if (kind_reg != see_pkg::CMD_WRITE)
                        state_reg <= see_pkg::MS_START;
                    end
                    see_pkg::SG_DATA: state_reg <= see_pkg::MS_STOP;
                    see_pkg::SG_DEVR: state_reg <= see_pkg::MS_RX;
                  endcase
                end
              end
            endcase
          end
          see_pkg::MS_RX:
          begin
            unique case (q_reg)
              see_pkg::Q_DRIVE:
                oe_reg <= (bit_reg == see_pkg::BYTE_BITS) && (remain_reg != 8'h00);
              see_pkg::Q_RISE: scl_reg <= 1'b1;
              see_pkg::Q_SAMPLE:
                if (bit_reg != see_pkg::BYTE_BITS)
                  sh_reg <= {sh_reg[6:0], sda_s2};
              see_pkg::Q_FALL:
              begin
                scl_reg <= 1'b0;
                if (bit_reg != see_pkg::BYTE_BITS)
                  bit_reg <= bit_reg + 4'h1;
                else if (remain_reg != 8'h00)
                begin
                  remain_reg <= remain_reg - 8'h01;
                  bit_reg <= 4'h0;
                end
                else
                  state_reg <= see_pkg::MS_STOP;
              end
            endcase
          end
          see_pkg::MS_STOP:
          begin
            unique case (q_reg)
              see_pkg::Q_DRIVE:
              begin
                scl_reg <= 1'b0;
                oe_reg <= 1'b1;
              end
              see_pkg::Q_RISE: scl_reg <= 1'b1;
              see_pkg::Q_SAMPLE: oe_reg <= 1'b0;
              see_pkg::Q_FALL:
              begin
                done <= 1'b1;
                state_reg <= see_pkg::MS_IDLE;
              end
            endcase
          end
          default: state_reg <= see_pkg::MS_IDLE;
        endcase
      end
    end
  end
endmodule : see_master

// ### rtl/see_pkg.sv
/*
  Shared constants and types for both ends of the serial EEPROM two-wire link.
  Assumes both ends run from one system clock at CLK_HZ.
*/
package see_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int SCL_HZ = 400_000;
  localparam int QUARTER_CYC = CLK_HZ / (4 * SCL_HZ);
  localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);
  localparam int PROG_INTERVAL_MS = 5;
  localparam int PROG_INTERVAL_CYC = (PROG_INTERVAL_MS * CLK_HZ) / 1000;
  localparam int BUSY_W = 20;

  // ------------------------------------------------------------
  // Formats
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam int PAGE_W = 3;
  localparam int SEL_W = 3;
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [1:0] Q_DRIVE = 2'h0;
  localparam logic [1:0] Q_RISE = 2'h1;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_FALL = 2'h3;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    DS_IDLE = 5'h01, DS_DEV = 5'h02, DS_ADDR = 5'h04, DS_WDATA = 5'h08, DS_READ = 5'h10
  } see_dev_state_t;
  typedef enum logic [4:0] {
    MS_IDLE = 5'h01, MS_START = 5'h02, MS_TX = 5'h04, MS_RX = 5'h08, MS_STOP = 5'h10
  } see_mst_state_t;
  typedef enum logic [3:0] {
    SG_DEVW = 4'h1, SG_ADDR = 4'h2, SG_DATA = 4'h4, SG_DEVR = 4'h8
  } see_stage_t;
  typedef enum logic [1:0] {
    CMD_CUR_READ = 2'h0, CMD_RAND_READ = 2'h1, CMD_WRITE = 2'h2
  } see_cmd_t;
endpackage : see_pkg

// ### rtl/see_if.sv
/*
  Two-wire link between the bus master end and the EEPROM device end.
  Assumes open-drain SDA with a pull-up; SCL is driven by the master only.
*/
interface see_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic sda;

  // The pull-up wins unless some end enables a low drive.
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport device (input scl, output s_sda_o, output s_sda_oe, input sda);
endinterface : see_if

// ### rtl/see_device.sv
/*
  EEPROM device end: 256-byte array behind the two-wire link, with current,
  random and sequential reads and byte or page writes into the array.
  Assumes SCL and SDA arrive asynchronously and are far slower than clock.
*/
module see_device
#(
  parameter int PROG_CYC = see_pkg::PROG_INTERVAL_CYC
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Straps
  input wire logic [2:0] chip_select_straps,
  // Status
  output logic busy,
  // Link
  see_if.device link
);
  see_pkg::see_dev_state_t state_reg;
  see_pkg::see_dev_state_t nxt_reg;
  logic [7:0] mem [see_pkg::MEM_DEPTH];
  logic [7:0] addr_reg;
  logic [7:0] sh_reg;
  logic [7:0] tx_reg;
  logic [3:0] cnt_reg;
  logic ackph_reg;
  logic mack_reg;
  logic wrote_reg;
  logic oe_reg;
  logic [see_pkg::BUSY_W-1:0] busy_cnt;
  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;
  logic [2:0] strap_s1, strap_s2;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic dev_match, byte_end, wr_en;
  logic [7:0] rd_byte;

  assign link.s_sda_o = 1'b0;
  assign link.s_sda_oe = oe_reg;

  // ------------------------------------------------------------
  // Pin synchronisers and condition detect
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
    end
    else
    begin
      scl_s1 <= link.scl;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      strap_s1 <= chip_select_straps;
      strap_s2 <= strap_s1;
    end
  end

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  // Both lines are sampled by the same clock, so an SDA edge with SCL high
  // on both samples is a real start or stop, not an SCL edge race.
  assign start_c = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_c = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign byte_end = scl_fall && !ackph_reg && (cnt_reg == see_pkg::BYTE_BITS);
  assign dev_match = (sh_reg[7:4] == see_pkg::DEV_TYPE) && (sh_reg[3:1] == strap_s2)
    && !busy;
  assign wr_en = byte_end && !start_c && !stop_c && (state_reg == see_pkg::DS_WDATA);
  assign rd_byte = mem[addr_reg];

  // ------------------------------------------------------------
  // Array
  // ------------------------------------------------------------
  // The array has no reset: contents persist like the real cells.
  always_ff @(posedge clock)
  begin
    if (wr_en)
      mem[addr_reg] <= sh_reg;
  end

  // ------------------------------------------------------------
  // Internal program interval
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      busy <= 1'b0;
      busy_cnt <= '0;
    end
    else if (stop_c && (state_reg == see_pkg::DS_WDATA) && wrote_reg && !busy)
    begin
      busy <= 1'b1;
      busy_cnt <= '0;
    end
    else if (busy)
    begin
      busy_cnt <= busy_cnt + see_pkg::BUSY_W'(1);
      if (busy_cnt == see_pkg::BUSY_W'(PROG_CYC - 1))
        busy <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Byte sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= see_pkg::DS_IDLE;
      nxt_reg <= see_pkg::DS_IDLE;
      addr_reg <= 8'h00;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      cnt_reg <= 4'h0;
      ackph_reg <= 1'b0;
      mack_reg <= 1'b0;
      wrote_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else if (start_c)
    begin
      state_reg <= see_pkg::DS_DEV;
      cnt_reg <= 4'h0;
      ackph_reg <= 1'b0;
      wrote_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else if (stop_c)
    begin
      state_reg <= see_pkg::DS_IDLE;
      ackph_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        see_pkg::DS_IDLE: oe_reg <= 1'b0;
        see_pkg::DS_DEV, see_pkg::DS_ADDR, see_pkg::DS_WDATA:
        begin
          if (scl_rise && !ackph_reg)
          begin
            sh_reg <= {sh_reg[6:0], sda_s2};
            cnt_reg <= cnt_reg + 4'h1;
          end
          if (scl_fall && ackph_reg)
          begin
            // Ack slot over: release, or drive the first read bit at once.
            ackph_reg <= 1'b0;
            cnt_reg <= 4'h0;
            state_reg <= nxt_reg;
            oe_reg <= 1'b0;
            if (nxt_reg == see_pkg::DS_READ)
            begin
              tx_reg <= rd_byte;
              oe_reg <= ~rd_byte[7];
              addr_reg <= addr_reg + 8'h01;
            end
          end
          else if (byte_end)
          begin
            oe_reg <= 1'b1;
            ackph_reg <= 1'b1;
            unique case (state_reg)
              see_pkg::DS_DEV:
              begin
                nxt_reg <= sh_reg[0] ? see_pkg::DS_READ : see_pkg::DS_ADDR;
                if (!dev_match)
                begin
                  oe_reg <= 1'b0;
                  ackph_reg <= 1'b0;
                  state_reg <= see_pkg::DS_IDLE;
                end
              end
              see_pkg::DS_ADDR:
              begin
                addr_reg <= sh_reg;
                nxt_reg <= see_pkg::DS_WDATA;
              end
              see_pkg::DS_WDATA:
              begin
                // Page writes roll within the page, keeping the row bits.
                addr_reg <= {addr_reg[7:see_pkg::PAGE_W],
                  addr_reg[see_pkg::PAGE_W-1:0] + see_pkg::PAGE_W'(1)};
                wrote_reg <= 1'b1;
                nxt_reg <= see_pkg::DS_WDATA;
              end
              default: nxt_reg <= see_pkg::DS_IDLE;
            endcase
          end
        end
        see_pkg::DS_READ:
        begin
          if (scl_rise && ackph_reg)
            mack_reg <= ~sda_s2;
          if (scl_fall && !ackph_reg)
          begin
            if (cnt_reg == see_pkg::LAST_BIT)
            begin
              oe_reg <= 1'b0;
              ackph_reg <= 1'b1;
            end
            else
            begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              oe_reg <= ~tx_reg[6];
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
          else if (scl_fall && ackph_reg)
          begin
            ackph_reg <= 1'b0;
            cnt_reg <= 4'h0;
            if (mack_reg)
            begin
              tx_reg <= rd_byte;
              oe_reg <= ~rd_byte[7];
              addr_reg <= addr_reg + 8'h01;
            end
            else
            begin
              oe_reg <= 1'b0;
              state_reg <= see_pkg::DS_IDLE;
            end
          end
        end
        default: state_reg <= see_pkg::DS_IDLE;
      endcase
    end
  end
endmodule : see_device

// ### dv/see_assertions.sv
/*
  Checker for the two-wire link between master and device ends.
  Assumes it sits beside the link interface, clocked by the system clock.
*/
module see_assertions
#(
  parameter logic [2:0] SEL = 3'h5
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Link
  input wire logic scl,
  input wire logic s_sda_oe,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);

  logic scl_q;
  logic sda_q;
  logic [3:0] cnt_reg;
  logic [1:0] byte_reg;
  logic [7:0] shift_reg;
  logic match_reg;
  logic rd_reg;
  logic nack_reg;
  logic hi;
  logic rise;
  logic fall;
  logic start_ev;
  logic stop_ev;
  logic id_ok;

  assign hi = scl & scl_q;
  assign rise = scl & ~scl_q;
  assign fall = ~scl & scl_q;
  assign start_ev = hi & sda_q & ~sda;
  assign stop_ev = hi & ~sda_q & sda;
  assign id_ok = shift_reg[7:1] == {see_pkg::DEV_TYPE, SEL};

  // ------------------------------------------------------------
  // Bit framing
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // A start clears the framing, so stray clocks of a stop or restart do no harm.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn || start_ev)
    begin
      cnt_reg <= 4'h0;
      byte_reg <= 2'h0;
      shift_reg <= 8'h00;
      match_reg <= 1'b0;
      rd_reg <= 1'b0;
      nack_reg <= 1'b0;
    end
    else if (rise)
    begin
      shift_reg <= {shift_reg[6:0], sda};
      cnt_reg <= (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
      if (cnt_reg == 4'h9 && byte_reg != 2'h3)
        byte_reg <= byte_reg + 2'h1;
      if (cnt_reg == 4'h8 && byte_reg == 2'h0)
      begin
        match_reg <= id_ok;
        rd_reg <= id_ok & shift_reg[0];
      end
    end
    else if (fall && cnt_reg == 4'h9 && rd_reg && sda_q)
      nack_reg <= 1'b1;
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_sda_moves_low;
    $changed(s_sda_oe) |-> !scl;
  endproperty
  a_sda_moves_low: assert property (p_sda_moves_low)
    else $error("device SDA moved while SCL high");

  property p_quiet_after_stop;
    stop_ev |=> !s_sda_oe [*8];
  endproperty
  a_quiet_after_stop: assert property (p_quiet_after_stop)
    else $error("device drives SDA after stop");

  property p_quiet_in_select;
    (byte_reg == 2'h0 && hi && cnt_reg inside {[4'h1:4'h8]}) |-> !s_sda_oe;
  endproperty
  a_quiet_in_select: assert property (p_quiet_in_select)
    else $error("device drives SDA during address byte");

  property p_select_ack;
    (byte_reg == 2'h0 && match_reg && hi && cnt_reg == 4'h9) |-> s_sda_oe;
  endproperty
  a_select_ack: assert property (p_select_ack)
    else $error("matching address byte not acknowledged");

  property p_word_addr_ack;
    (byte_reg == 2'h1 && match_reg && !rd_reg && hi && cnt_reg == 4'h9) |-> s_sda_oe;
  endproperty
  a_word_addr_ack: assert property (p_word_addr_ack)
    else $error("word address byte not acknowledged");

  property p_nack_release;
    nack_reg |-> !s_sda_oe;
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("device drives SDA after master nack");

  property p_master_slot_free;
    (rd_reg && byte_reg != 2'h0 && hi && cnt_reg == 4'h9) |-> !s_sda_oe;
  endproperty
  a_master_slot_free: assert property (p_master_slot_free)
    else $error("device holds SDA in master ack slot");

  property p_ack_holds;
    (hi && cnt_reg == 4'h9 && s_sda_oe) |=> (s_sda_oe || !scl);
  endproperty
  a_ack_holds: assert property (p_ack_holds)
    else $error("device ack dropped while SCL high");
endmodule : see_assertions

// ### dv/testbench.sv
/*
  Self-checking bench: master and device ends joined by one link.
  Assumes the package, interface, both ends and the checker compile first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] STRAPS = 3'h5;
  localparam int PROG_SIM = 200;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  see_pkg::see_cmd_t cmd_kind = see_pkg::CMD_CUR_READ;
  logic [2:0] cmd_sel = 3'h0;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [7:0] cmd_len = 8'h00;
  logic rd_valid;
  logic rd_ready = 1'b0;
  logic [7:0] rd_data;
  logic done;
  logic nack;
  logic busy;
  logic [7:0] exp_mem [256];
  int err_total = 0;
  int checks_done = 0;
  int wait_len;

  see_if link_if();
  see_master u_see_master(.clock, .rstn, .cmd_valid, .cmd_ready, .cmd_kind, .cmd_sel,
    .cmd_addr, .cmd_wdata, .cmd_len, .rd_valid, .rd_ready, .rd_data, .done, .nack,
    .link(link_if.master));
  see_device #(.PROG_CYC(PROG_SIM)) u_see_device(.clock, .rstn, .chip_select_straps(STRAPS),
    .busy, .link(link_if.device));
  see_assertions #(.SEL(STRAPS)) u_see_assertions(.clock, .rstn, .scl(link_if.scl),
    .s_sda_oe(link_if.s_sda_oe), .sda(link_if.sda));

  always #5 clock = ~clock;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_for(ref logic flag, input logic level);
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (flag !== level && n < 60000);
    wait_len = n;
    if (n >= 60000)
      check(8'h00, 8'h01);
  endtask : wait_for

  task automatic run_cmd(input see_pkg::see_cmd_t k, input logic [2:0] s,
    input logic [7:0] a, input logic [7:0] w, input logic [7:0] n);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_sel <= s;
    cmd_addr <= a;
    cmd_wdata <= w;
    cmd_len <= n;
    wait_for(cmd_ready, 1'b1);
    cmd_valid <= 1'b0;
    wait_for(done, 1'b1);
  endtask : run_cmd

  // A long stall lets the two-entry buffer fill so the master must stretch.
  task automatic read_seq(input see_pkg::see_cmd_t k, input logic [2:0] s,
    input logic [7:0] a, input logic [7:0] first, input int n, input int stall);
    fork
      run_cmd(k, s, a, 8'h00, 8'(n - 1));
      begin
        repeat (stall) @(posedge clock);
        for (int i = 0; i < n; i++)
        begin
          wait_for(rd_valid, 1'b1);
          check(rd_data, exp_mem[first + 8'(i)]);
          rd_ready <= 1'b1;
          @(posedge clock);
          rd_ready <= 1'b0;
        end
      end
    join
  endtask : read_seq

  task automatic print_verdict;
    $display("Counts: %0d compares, %0d mismatches", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    logic [7:0] wa;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      wa = 8'hff + 8'(i);
      exp_mem[wa] = wa ^ 8'h96;
      run_cmd(see_pkg::CMD_WRITE, STRAPS, wa, exp_mem[wa], 8'h00);
      check({7'h0, nack}, 8'h00);
      check({7'h0, busy}, 8'h01);
      wait_for(busy, 1'b0);
      check({7'h0, wait_len <= PROG_SIM}, 8'h01);
      // Done trails the stop by about one quarter, so busy must outlast the rest.
      check({7'h0, wait_len > PROG_SIM - see_pkg::QUARTER_CYC}, 8'h01);
    end
    $display("Test writes across the top address ended");
    read_seq(see_pkg::CMD_RAND_READ, STRAPS, 8'hff, 8'hff, 3, 14000);
    check({7'h0, nack}, 8'h00);
    $display("Test random sequential read with wrap ended");
    read_seq(see_pkg::CMD_CUR_READ, STRAPS, 8'h00, 8'h02, 2, 0);
    $display("Test current address read ended");
    run_cmd(see_pkg::CMD_CUR_READ, ~STRAPS, 8'h00, 8'h00, 8'h00);
    check({7'h0, nack}, 8'h01);
    read_seq(see_pkg::CMD_RAND_READ, STRAPS, 8'h00, 8'h00, 1, 0);
    check({7'h0, nack}, 8'h00);
    $display("Test foreign select then recovery ended");
    print_verdict();
  end

  initial
  begin
    repeat (100000) @(posedge clock);
    err_total++;
    print_verdict();
  end
endmodule : testbench
